// File: logic/crpc_pin_sync.sv
// two-stage synchroniser for the reset pin level
`timescale 1ns/100ps
module crpc_pin_sync (
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic rst,
   // pin and synchronised level
   input  wire logic pin_in,
   output logic      pin_sync
);
   logic meta_reg;
   logic sync_reg;

   // first stage feeds only the second; idles high like a released pin
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         meta_reg <= 1'b1;
         sync_reg <= 1'b1;
      end else begin
         meta_reg <= pin_in;
         sync_reg <= meta_reg;
      end
   end

   assign pin_sync = sync_reg;
endmodule : crpc_pin_sync

// File: logic/crpc_pkg.sv
// constants and types for the clock, reset and power-down controller
package crpc_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0]  IDX_CLK_DIV    = 8'hD4;
   localparam logic [7:0]  IDX_OSC_SEL    = 8'hD6;
   localparam logic [7:0]  IDX_HALT_PERM  = 8'hD7;
   localparam logic [7:0]  IDX_STAB       = 8'hDC;
   localparam logic [7:0]  IDX_WDT        = 8'hE5;
   localparam logic [7:0]  IDX_PWR_CMD    = 8'hC0;
   localparam logic [7:0]  IDX_STATUS     = 8'hC1;
   localparam int          ADDR_W         = 10;

   // field positions
   localparam int          DIV_LSB        = 3;
   localparam int          OSC_SUB_BIT    = 0;
   localparam int          SUB_STOP_BIT   = 2;
   localparam int          MAIN_STOP_BIT  = 3;
   localparam int          WDT_KEY_LSB    = 4;
   localparam int          WDT_CLR_BIT    = 0;
   localparam int          PWR_IDLE_BIT   = 0;
   localparam int          PWR_HALT_BIT   = 1;

   // divider encodings
   localparam logic [1:0]  DIV_BY_1       = 2'h0;
   localparam logic [1:0]  DIV_BY_2       = 2'h1;
   localparam logic [1:0]  DIV_BY_8       = 2'h2;
   localparam logic [1:0]  DIV_BY_16      = 2'h3;

   // reset values and keys
   localparam logic [1:0]  DIV_RST        = DIV_BY_16;
   localparam logic [7:0]  HALT_PERM_RST  = 8'h00;
   localparam logic [1:0]  STAB_SEL_RST   = 2'h0;
   localparam logic [3:0]  WDT_KEY_RST    = 4'h0;
   localparam logic [3:0]  WDT_OFF_KEY    = 4'hA;
   localparam logic [7:0]  HALT_KEY       = 8'h5A;
   localparam logic [15:0] RESET_VECTOR   = 16'h0100;
   // ports 4..0, 8 pins each; a one forces the pin to input at reset
   localparam logic [39:0] PORT_IN_MASK   = 40'hFF87FFFFF8;

   // timing
   localparam int          CLK_MHZ        = 125;
   localparam int          OSC_STAB_US    = 1000;
   localparam int          OSC_STAB_CYC   = OSC_STAB_US * CLK_MHZ;
   localparam int          STAB_W         = 20;

   typedef enum logic [4:0] {
      ST_RESET = 5'h01,
      ST_STAB  = 5'h02,
      ST_RUN   = 5'h04,
      ST_IDLE  = 5'h08,
      ST_HALT  = 5'h10
   } crpc_state_e;
endpackage : crpc_pkg

// File: logic/crpc_top.sv
// clock divider, power-down modes, reset sequence and watchdog
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/100ps
module crpc_top
   import crpc_pkg::*;
#(
   parameter int STAB_CYCLES = crpc_pkg::OSC_STAB_CYC,
   parameter int WDT_W       = 16
) (
   // clock and reset
   input  wire logic                          ref_clk,
   input  wire logic                          rst,
   // avalon-mm slave
   input  wire logic [crpc_pkg::ADDR_W-1:0]   avs_address,
   input  wire logic                          avs_read,
   input  wire logic                          avs_write,
   input  wire logic [31:0]                   avs_writedata,
   input  wire logic [3:0]                    avs_byteenable,
   output logic      [31:0]                   avs_readdata,
   output logic                               avs_waitrequest,
   // pins and wake sources
   input  wire logic                          reset_pin_n,
   input  wire logic                          test_pin,
   input  wire logic                          ext_irq_filtered,
   input  wire logic                          int_irq,
   input  wire logic                          watch_on_sub,
   // oscillator and clock enables
   output logic                               main_osc_en,
   output logic                               sub_osc_en,
   output logic                               cpu_clk_en,
   output logic                               periph_clk_en,
   // reset sequence outputs
   output logic                               sys_reset,
   output logic                               irq_force_off,
   output logic                               wdt_enabled,
   output logic      [39:0]                   port_force_input,
   output logic                               pc_load,
   output logic      [15:0]                   pc_load_value,
   output logic                               cpu_fetch_en,
   output logic                               rom_access_en
);
   import crpc_pkg::*;

   typedef struct packed {
      crpc_state_e        state;
      logic [1:0]         div_sel;
      logic               osc_sub;
      logic               main_stop;
      logic               sub_stop;
      logic [7:0]         halt_perm;
      logic [1:0]         stab_sel;
      logic [3:0]         wdt_key;
      logic [WDT_W-1:0]   wdt_cnt;
      logic [3:0]         div_cnt;
      logic [STAB_W-1:0]  stab_cnt;
      logic               ack;
      logic [7:0]         rdata;
      logic [15:0]        pc_val;
      logic               rom_en;
      logic               cpu_tick;
   } crpc_state_s;

   crpc_state_s st_reg;
   crpc_state_s st_next;

   logic             pin_level;
   logic             pin_reset;
   logic             wdt_overflow;
   logic             sys_rst_evt;
   logic             bus_req;
   logic             bus_take;
   logic [7:0]       idx;
   logic             idx_ok;
   logic [7:0]       wbyte;
   logic             main_run;
   logic             sub_run;
   logic             div_hit;
   logic [STAB_W-1:0] stab_load;

   ////////////////////////////////////////////////////////////////////
   // reset pin

   crpc_pin_sync u_pin_sync (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .pin_in   (reset_pin_n),
      .pin_sync (pin_level)
   );

   assign pin_reset = ~pin_level;

   // overflow is the all-ones count, so the reset lands before the wrap
   // watchdog overflow resets system
   assign wdt_overflow = (&st_reg.wdt_cnt) && (st_reg.wdt_key != WDT_OFF_KEY);
   assign sys_rst_evt  = pin_reset || wdt_overflow;

   ////////////////////////////////////////////////////////////////////
   // bus decode

   assign bus_req  = avs_read || avs_write;
   // one wait cycle, then the answer; the master holds the request meanwhile
   assign bus_take = bus_req && st_reg.ack;
   assign idx      = avs_address[ADDR_W-1:2];
   assign idx_ok   = (avs_address[1:0] == 2'h0);
   assign wbyte    = avs_writedata[7:0];

   // the sub clock itself is not modelled: with sub selected the cpu still ticks from
   // the main divider, so stopping main also stops the cpu tick
   // main selected: main cannot be stopped by register
   assign main_run = (st_reg.state != ST_HALT) && !(st_reg.osc_sub && st_reg.main_stop);
   // sub selected: sub cannot be stopped by register
   assign sub_run  = st_reg.osc_sub || !st_reg.sub_stop;

   always_comb begin
      case (st_reg.div_sel)
         DIV_BY_1: div_hit = 1'b1;
         DIV_BY_2: div_hit = (st_reg.div_cnt[0] == 1'b1);
         DIV_BY_8: div_hit = (st_reg.div_cnt[2:0] == 3'h7);
         default:  div_hit = (st_reg.div_cnt == 4'hF);
      endcase
   end

   // shorter intervals are the base count halved per step of the setting
   // a zero-length interval still costs one cycle in the stabilization state
   assign stab_load = STAB_W'(STAB_CYCLES >> st_reg.stab_sel);

   ////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      st_next          = st_reg;
      st_next.ack      = bus_req && !st_reg.ack;
      // the divider runs free, so the first tick after a change may come early
      st_next.div_cnt  = main_run ? st_reg.div_cnt + 4'h1 : st_reg.div_cnt;
      st_next.cpu_tick = 1'b0;

      // register read; unmapped words read zero
      // the word is captured in the wait cycle and stands through the answer cycle
      if (bus_req && !st_reg.ack) begin
         st_next.rdata = 8'h00;
         if (avs_read && idx_ok) begin
            case (idx)
               IDX_CLK_DIV:   st_next.rdata[DIV_LSB +: 2] = st_reg.div_sel;
               IDX_OSC_SEL: begin
                  st_next.rdata[OSC_SUB_BIT]   = st_reg.osc_sub;
                  st_next.rdata[SUB_STOP_BIT]  = st_reg.sub_stop;
                  st_next.rdata[MAIN_STOP_BIT] = st_reg.main_stop;
               end
               IDX_HALT_PERM: st_next.rdata = st_reg.halt_perm;
               IDX_STAB:      st_next.rdata[1:0] = st_reg.stab_sel;
               IDX_WDT:       st_next.rdata[WDT_KEY_LSB +: 4] = st_reg.wdt_key;
               IDX_STATUS:    st_next.rdata = {1'b0, main_run, sub_run, st_reg.state};
               default:       st_next.rdata = 8'h00;
            endcase
         end
      end

      // watchdog runs while the main clock is up; a clear written below wins
      // a disabled watchdog keeps its count and resumes from it when enabled again
      if (st_reg.wdt_key != WDT_OFF_KEY && main_run) begin
         st_next.wdt_cnt = st_reg.wdt_cnt + 1'b1;
      end

      if (bus_take && avs_write && idx_ok && avs_byteenable[0]) begin
         case (idx)
            IDX_CLK_DIV: st_next.div_sel = wbyte[DIV_LSB +: 2];
            IDX_OSC_SEL: begin
               st_next.osc_sub   = wbyte[OSC_SUB_BIT];
               st_next.sub_stop  = wbyte[SUB_STOP_BIT];
               st_next.main_stop = wbyte[MAIN_STOP_BIT];
            end
            IDX_HALT_PERM: st_next.halt_perm = wbyte;
            IDX_STAB: st_next.stab_sel = wbyte[1:0];
            IDX_WDT: begin
               st_next.wdt_key = wbyte[WDT_KEY_LSB +: 4];
               if (wbyte[WDT_CLR_BIT]) begin
                  st_next.wdt_cnt = '0;
               end
            end
            IDX_PWR_CMD: begin
               if (st_reg.state == ST_RUN) begin
                  // halt needs the permission key; it is spent on use
                  if (wbyte[PWR_HALT_BIT] && st_reg.halt_perm == HALT_KEY) begin
                     st_next.state     = ST_HALT;
                     st_next.halt_perm = HALT_PERM_RST;
                  end else if (wbyte[PWR_IDLE_BIT]) begin
                     st_next.state = ST_IDLE;
                  end
               end
            end
            default: ;
         endcase
      end

      case (st_reg.state)
         ST_RESET: begin
            // strap sampled while the reset state lasts
            st_next.rom_en = !test_pin;
            if (!pin_reset) begin
               st_next.state    = ST_STAB;
               st_next.stab_cnt = stab_load;
            end
         end
         ST_STAB: begin
            // fetch waits for the full interval
            if (st_reg.stab_cnt <= STAB_W'(1)) begin
               st_next.state = ST_RUN;
            end else begin
               st_next.stab_cnt = st_reg.stab_cnt - STAB_W'(1);
            end
         end
         ST_RUN: begin
            // cpu ticks at the selected rate
            st_next.cpu_tick = div_hit && main_run;
         end
         ST_IDLE: begin
            if (ext_irq_filtered || int_irq) begin
               st_next.state = ST_RUN;
            end
         end
         ST_HALT: begin
            // internal wake only on sub clock
            if (ext_irq_filtered || (int_irq && sub_run && watch_on_sub)) begin
               st_next.state    = ST_STAB;
               st_next.stab_cnt = stab_load;
            end
         end
         default: st_next.state = ST_RESET;
      endcase

      // every control register back to default
      if (sys_rst_evt) begin
         st_next.state     = ST_RESET;
         st_next.div_sel   = DIV_RST;
         st_next.osc_sub   = 1'b0;
         st_next.main_stop = 1'b0;
         st_next.sub_stop  = 1'b0;
         st_next.halt_perm = HALT_PERM_RST;
         st_next.stab_sel  = STAB_SEL_RST;
         st_next.wdt_key   = WDT_KEY_RST;
         st_next.wdt_cnt   = '0;
         st_next.cpu_tick  = 1'b0;
         st_next.pc_val    = RESET_VECTOR;
         // test pin low selects internal rom
         st_next.rom_en    = !test_pin;
      end

      // a tick must not outlive the run state or the main clock, or the cpu
      // would see an edge after it was told to stop
      if (st_next.state != ST_RUN || (st_next.osc_sub && st_next.main_stop)) begin
         st_next.cpu_tick = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st_reg           <= '0;
         st_reg.state     <= ST_RESET;
         st_reg.div_sel   <= DIV_RST;
         st_reg.halt_perm <= HALT_PERM_RST;
         st_reg.stab_sel  <= STAB_SEL_RST;
         st_reg.wdt_key   <= WDT_KEY_RST;
         st_reg.pc_val    <= RESET_VECTOR;
      end else begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs

   assign avs_waitrequest = bus_req && !st_reg.ack;
   assign avs_readdata    = {24'h000000, st_reg.rdata};
   assign main_osc_en     = main_run;
   assign sub_osc_en      = sub_run;
   // idle stops only the cpu clock
   assign cpu_clk_en      = st_reg.cpu_tick;
   assign periph_clk_en   = main_run && (st_reg.state == ST_RUN || st_reg.state == ST_IDLE);
   // reset-time outputs sys_reset, irq_force_off, port_force_input and pc_load decode ST_RESET of the state register, so they rise and fall together
   assign sys_reset       = (st_reg.state == ST_RESET);
   assign irq_force_off   = (st_reg.state == ST_RESET);
   assign wdt_enabled     = (st_reg.wdt_key != WDT_OFF_KEY);
   // ports forced to input, listed pins kept
   assign port_force_input = (st_reg.state == ST_RESET) ? PORT_IN_MASK : 40'h0000000000;
   assign pc_load         = (st_reg.state == ST_RESET);
   assign pc_load_value   = st_reg.pc_val;
   assign cpu_fetch_en    = (st_reg.state == ST_RUN);
   assign rom_access_en   = st_reg.rom_en;
endmodule : crpc_top

// File: verification/crpc_checker.sv
// concurrent checks on the ports of the clock, reset and power-down controller
`timescale 1ns/100ps
module crpc_checker
   import crpc_pkg::*;
(
   // clock and reset
   input wire logic        ref_clk,
   input wire logic        rst,
   // bus handshake and pin
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic        avs_waitrequest,
   input wire logic        reset_pin_n,
   // clock enables
   input wire logic        main_osc_en,
   input wire logic        cpu_clk_en,
   input wire logic        periph_clk_en,
   // reset sequence outputs
   input wire logic        sys_reset,
   input wire logic        irq_force_off,
   input wire logic        wdt_enabled,
   input wire logic [39:0] port_force_input,
   input wire logic        pc_load,
   input wire logic [15:0] pc_load_value,
   input wire logic        cpu_fetch_en
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////////////
   req_first_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
      else $error("bus answer came in the request cycle");
   req_ack_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus answer missing in second cycle");
   halt_clocks_a: assert property (!main_osc_en |-> !cpu_clk_en && !periph_clk_en)
      else $error("clock enable while main oscillator stopped");
   idle_gate_a: assert property (cpu_clk_en |-> cpu_fetch_en)
      else $error("cpu tick outside run state");
   reset_effects_a: assert property (sys_reset |-> irq_force_off && pc_load && wdt_enabled)
      else $error("reset side effect missing");
   port_input_a: assert property (port_force_input == (sys_reset ? PORT_IN_MASK : 40'h0))
      else $error("port input forcing wrong");
   pc_vector_a: assert property (pc_load |-> pc_load_value == RESET_VECTOR)
      else $error("program counter load value wrong");
   stab_wait_a: assert property ($fell(sys_reset) |-> !cpu_fetch_en [*2])
      else $error("fetch before stabilization");
   pin_reset_a: assert property ($fell(reset_pin_n) |-> ##[1:4] sys_reset)
      else $error("reset pin not taken within four cycles");
   rst_entry_a: assert property ($fell(rst) |-> sys_reset)
      else $error("reset state not entered");
   cover property ($fell(main_osc_en));
   cover property ($fell(cpu_fetch_en) && periph_clk_en);
   cover property ($rose(sys_reset));
endmodule : crpc_checker

bind crpc_top crpc_checker i_chk (.ref_clk, .rst, .avs_read, .avs_write, .avs_waitrequest,
   .reset_pin_n, .main_osc_en, .cpu_clk_en, .periph_clk_en, .sys_reset, .irq_force_off,
   .wdt_enabled, .port_force_input, .pc_load, .pc_load_value, .cpu_fetch_en);

// File: verification/crpc_pin_model.sv
// external reset source and test pin strap
`timescale 1ns/100ps
module crpc_pin_model #(
   parameter int LOW_CYCLES = 20
) (
   // clock and request
   input  wire logic ref_clk,
   input  wire logic pulse_req,
   // pins
   output logic      reset_pin_n,
   output logic      test_pin
);
   int cnt = 0;
   always @(posedge ref_clk) begin
      if (pulse_req) cnt <= LOW_CYCLES;
      else if (cnt > 0) cnt <= cnt - 1;
   end
   assign reset_pin_n = (cnt == 0);
   assign test_pin = 1'b0;
endmodule : crpc_pin_model

// File: verification/testbench.sv
// self-checking bench for the clock, reset and power-down controller
`timescale 1ns/100ps
module testbench;
   import crpc_pkg::*;
   localparam int STAB = 20;
   logic ref_clk, rst, avs_read, avs_write, avs_waitrequest, pin_req, reset_pin_n, test_pin;
   logic [9:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [3:0] avs_byteenable;
   logic ext_irq, int_irq, watch_on_sub, main_osc_en, sub_osc_en, cpu_clk_en, periph_clk_en;
   logic sys_reset, irq_force_off, wdt_enabled, pc_load, cpu_fetch_en, rom_access_en;
   logic [39:0] port_force_input;
   logic [15:0] pc_load_value;
   int mismatches = 0;
   int compares = 0;
   crpc_top #(.STAB_CYCLES(STAB), .WDT_W(8)) i_dut (.ref_clk, .rst, .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
      .reset_pin_n, .test_pin, .ext_irq_filtered(ext_irq), .int_irq, .watch_on_sub,
      .main_osc_en, .sub_osc_en, .cpu_clk_en, .periph_clk_en, .sys_reset, .irq_force_off,
      .wdt_enabled, .port_force_input, .pc_load, .pc_load_value, .cpu_fetch_en, .rom_access_en);
   crpc_pin_model #(.LOW_CYCLES(STAB)) i_pin (.ref_clk, .pulse_req(pin_req), .reset_pin_n,
      .test_pin);
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d,
                      input logic [3:0] be, output logic [31:0] q);
      @(posedge ref_clk);
      avs_address <= {idx, 2'h0};
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= {24'h0, d};
      avs_byteenable <= be;
      // the request stands until the rising edge that samples waitrequest low
      do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, idx, d, 4'h1, q);
   endtask : wr
   task automatic rd_chk(input string what, input logic [7:0] idx, input logic [7:0] exp);
      logic [31:0] q;
      bus(1'b0, idx, 8'h00, 4'h1, q);
      chk(what, {32'h0, exp}, {8'h0, q});
   endtask : rd_chk
   task automatic wait_fetch(output int n);
      n = 0;
      while (cpu_fetch_en !== 1'b1 && n < 1000) begin
         @(negedge ref_clk);
         n++;
      end
      chk("fetch reached", 1, cpu_fetch_en);
   endtask : wait_fetch
   task automatic period(output int p);
      p = 0;
      do @(negedge ref_clk); while (cpu_clk_en !== 1'b1);
      do begin
         @(negedge ref_clk);
         p++;
      end while (cpu_clk_en !== 1'b1 && p < 40);
   endtask : period
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      int n;
      wr(IDX_WDT, {WDT_OFF_KEY, 4'h0});
      @(negedge ref_clk);
      chk("watchdog off", 0, wdt_enabled);
      chk("rom access after reset", 1, rom_access_en);
      rd_chk("divider after reset", IDX_CLK_DIV, 8'h18);
      rd_chk("halt permission after reset", IDX_HALT_PERM, 8'h00);
      wait_fetch(n);
      $display("t_reset done");
   endtask : t_reset
   task automatic t_div();
      int p;
      int exp [4] = '{1, 2, 8, 16};
      for (int s = 0; s < 4; s++) begin
         wr(IDX_CLK_DIV, 8'(s) << DIV_LSB);
         rd_chk("divider readback", IDX_CLK_DIV, 8'(s) << DIV_LSB);
         period(p);
         period(p);
         chk("cpu tick period", 40'(exp[s]), 40'(p));
      end
      $display("t_div done");
   endtask : t_div
   task automatic t_refuse();
      logic [31:0] q;
      bus(1'b1, IDX_CLK_DIV, 8'h08, 4'h0, q);
      rd_chk("write without lane", IDX_CLK_DIV, 8'h18);
      bus(1'b1, 8'hDA, 8'hFF, 4'h1, q);
      rd_chk("unmapped read", 8'hDA, 8'h00);
      $display("t_refuse done");
   endtask : t_refuse
   task automatic t_osc();
      wr(IDX_OSC_SEL, 8'h0C);
      @(negedge ref_clk);
      chk("main kept, main selected", 1, main_osc_en);
      chk("sub stopped, main selected", 0, sub_osc_en);
      wr(IDX_OSC_SEL, 8'h0D);
      @(negedge ref_clk);
      chk("main stopped, sub selected", 0, main_osc_en);
      chk("sub kept, sub selected", 1, sub_osc_en);
      wr(IDX_OSC_SEL, 8'h00);
      $display("t_osc done");
   endtask : t_osc
   task automatic t_idle();
      int n;
      for (int k = 0; k < 2; k++) begin
         wr(IDX_PWR_CMD, 8'h01);
         repeat (20) @(negedge ref_clk);
         chk("fetch in idle", 0, cpu_fetch_en);
         chk("peripheral clock in idle", 1, periph_clk_en);
         rd_chk("status in idle", IDX_STATUS, {2'b01, 1'b1, ST_IDLE});
         @(posedge ref_clk);
         if (k == 0) int_irq <= 1'b1;
         else ext_irq <= 1'b1;
         wait_fetch(n);
         chk("idle wake", 1, n <= 3);
         @(posedge ref_clk);
         int_irq <= 1'b0;
         ext_irq <= 1'b0;
      end
      $display("t_idle done");
   endtask : t_idle
   task automatic t_halt();
      int n;
      wr(IDX_STAB, 8'h01);
      wr(IDX_PWR_CMD, 8'h02);
      @(negedge ref_clk);
      chk("halt without key", 1, main_osc_en);
      for (int k = 0; k < 2; k++) begin
         wr(IDX_HALT_PERM, HALT_KEY);
         wr(IDX_PWR_CMD, 8'h02);
         @(posedge ref_clk);
         int_irq <= 1'b1;
         repeat (10) @(negedge ref_clk);
         chk("main stopped in halt", 0, main_osc_en);
         @(posedge ref_clk);
         if (k == 0) ext_irq <= 1'b1;
         else watch_on_sub <= 1'b1;
         wait_fetch(n);
         chk("halt wake interval", 1, n >= STAB / 2 && n <= STAB / 2 + 6);
         chk("main restarted", 1, main_osc_en);
         @(posedge ref_clk);
         int_irq <= 1'b0;
         ext_irq <= 1'b0;
         watch_on_sub <= 1'b0;
      end
      $display("t_halt done");
   endtask : t_halt
   task automatic t_pin();
      int n;
      wr(IDX_CLK_DIV, 8'h00);
      @(posedge ref_clk);
      pin_req <= 1'b1;
      @(posedge ref_clk);
      pin_req <= 1'b0;
      repeat (8) @(negedge ref_clk);
      chk("pin reset taken", 1, sys_reset);
      chk("interrupts off", 1, irq_force_off);
      chk("watchdog on", 1, wdt_enabled);
      chk("ports input", PORT_IN_MASK, port_force_input);
      chk("reset vector", 40'(RESET_VECTOR), 40'(pc_load_value));
      n = 0;
      while (sys_reset !== 1'b0 && n < 100) begin
         @(negedge ref_clk);
         n++;
      end
      wait_fetch(n);
      chk("stabilization before fetch", 1, n >= STAB - 1 && n <= STAB + 4);
      chk("rom access", 1, rom_access_en);
      wr(IDX_WDT, {WDT_OFF_KEY, 4'h0});
      rd_chk("divider back to default", IDX_CLK_DIV, 8'h18);
      rd_chk("interval select default", IDX_STAB, 8'h00);
      $display("t_pin done");
   endtask : t_pin
   task automatic t_wdt();
      int n;
      wr(IDX_WDT, 8'h01);
      n = 0;
      while (sys_reset !== 1'b1 && n < 400) begin
         @(negedge ref_clk);
         n++;
      end
      chk("watchdog overflow reset", 1, n >= 240 && n <= 260);
      wait_fetch(n);
      wr(IDX_WDT, {WDT_OFF_KEY, 4'h0});
      $display("t_wdt done");
   endtask : t_wdt
   task automatic test_done();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : test_done
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   // the whole run needs about 700 cycles
   initial begin
      repeat (20000) @(posedge ref_clk);
      mismatches++;
      test_done();
   end
   initial begin
      {rst, pin_req, avs_read, avs_write, ext_irq, int_irq, watch_on_sub} = 7'h40;
      avs_address = 10'h0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'h0;
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      t_reset();
      t_div();
      t_refuse();
      t_osc();
      t_idle();
      t_halt();
      t_pin();
      t_wdt();
      test_done();
   end
endmodule : testbench
